// File: wcl_pkg.sv
package wcl_pkg;
  localparam logic [4:0] OFS_FLAG_ATTRIBUTES_REG = 5'h00;
  localparam logic [4:0] OFS_HARDWARE_CONFIG_REG = 5'h04;
  localparam logic [4:0] OFS_LED_MODE = 5'h08;
  localparam logic [4:0] OFS_LED_BEHAV = 5'h0c;
  localparam logic [4:0] OFS_CTRL = 5'h10;
  localparam logic [4:0] OFS_INT_STS = 5'h14;
  localparam logic [4:0] OFS_INT_MASK = 5'h18;
  localparam logic [2:0] NV_WAKE0 = 3'h0;
  localparam logic [2:0] NV_WAKE1 = 3'h1;
  localparam logic [2:0] NV_LED0 = 3'h2;
  localparam logic [2:0] NV_LED1 = 3'h3;
  localparam logic [2:0] NV_LED2 = 3'h4;
  localparam logic [2:0] NV_LED3 = 3'h5;
  localparam int WK_MASTER = 7;
  localparam int WK_PDA = 0;
  localparam int WK_BUF = 14;
  localparam int WK_ATT_EN = 13;
  localparam int WK_ATT_POL = 12;
  localparam int WK_BCAST = 9;
  localparam int WK_FRAME = 8;
  localparam logic [7:0] WK1_USED = 8'h73;
  localparam logic [7:0] LED0_USED = 8'h0f;
  localparam int HW_PROT = 4;
  localparam int HW_LOADED = 8;
  localparam int HW_HSIC = 9;
  localparam int CTRL_RELOAD = 0;
  localparam int EV_DONE = 0;
  localparam int EV_ATTACH = 1;
  localparam int EV_ABSENT = 2;
  localparam logic [15:0] FLAG_ATTRIBUTES_REG_RST = 16'h0000;
  localparam logic [3:0] LED_EN_RST = 4'h0;
  localparam logic [15:0] LED_MODE_RST = 16'h0000;
  localparam logic [15:0] LED_BEHAV_RST = 16'h0000;
  localparam logic [2:0] INT_RST = 3'h0;

  typedef enum logic [1:0] {ST_BOOT, ST_FETCH, ST_FINISH, ST_IDLE} wcl_fsm_t;

  typedef struct packed {
    wcl_fsm_t state;
    logic [2:0] idx;
    logic loaded;
    logic [15:0] flag_attributes_reg;
    logic [3:0] led_en;
    logic rst_prot;
    logic [15:0] led_mode;
    logic [15:0] led_behav;
    logic [2:0] int_sts;
    logic [2:0] int_mask;
    logic irq;
    logic [31:0] prdata;
    logic [3:0] led;
    logic attach_act;
    logic attach;
    logic attach_oe;
    logic [2:0] wake;
    logic wakeup_frame_filter_load;
  } wcl_state_t;
endpackage

// File: wcl_loader.sv
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module wcl_loader (
  input wire logic CLOCK_I,
  input wire logic RESET_N_I,
  input wire logic SOFT_RESET_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [4:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic NVM_PRESENT_I,
  output logic NVM_REQ_O,
  output logic [2:0] NVM_ADDR_O,
  input wire logic NVM_ACK_I,
  input wire logic [7:0] NVM_DATA_I,
  input wire logic HSIC_MODE_I,
  input wire logic USB_READY_I,
  input wire logic [15:0] LED_STATUS_I,
  output logic [3:0] LED_O,
  output logic ATTACH_O,
  output logic ATTACH_OE_O,
  output logic [2:0] WAKE_EN_O,
  output logic WAKE_FILTER0_LOAD_O,
  output logic IRQ_O
);

  wcl_pkg::wcl_state_t s;
  wcl_pkg::wcl_state_t n;
  logic [3:0] led_next;
  logic [2:0] ev;
  logic wr;
  logic att_en;

  function automatic logic is_mapped(input logic [4:0] a);
    is_mapped = (a == wcl_pkg::OFS_FLAG_ATTRIBUTES_REG) || (a == wcl_pkg::OFS_HARDWARE_CONFIG_REG) ||
                (a == wcl_pkg::OFS_LED_MODE) || (a == wcl_pkg::OFS_LED_BEHAV) ||
                (a == wcl_pkg::OFS_CTRL) || (a == wcl_pkg::OFS_INT_STS) ||
                (a == wcl_pkg::OFS_INT_MASK);
  endfunction

  // each led shows the status line its select picks, when enabled
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_led
      assign led_next[gi] = s.led_en[gi] & LED_STATUS_I[s.led_mode[4*gi +: 4]];
    end
  endgenerate

  assign wr = PSEL_I & PENABLE_I & PWRITE_I;
  assign att_en = s.flag_attributes_reg[wcl_pkg::WK_ATT_EN] & HSIC_MODE_I;

  always_comb begin
    n = s;
    ev = 3'h0;
    n.wakeup_frame_filter_load = 1'b0;
    case (s.state)
      wcl_pkg::ST_BOOT: begin
        n.idx = wcl_pkg::NV_WAKE0;
        n.loaded = 1'b0;
        if (NVM_PRESENT_I) begin
          n.state = wcl_pkg::ST_FETCH;
        end else begin
          // no store: registers keep the values they already hold
          ev[wcl_pkg::EV_ABSENT] = 1'b1;
          n.loaded = 1'b1;
          n.state = wcl_pkg::ST_IDLE;
        end
      end
      wcl_pkg::ST_FETCH: begin
        if (NVM_ACK_I) begin
          case (s.idx)
            wcl_pkg::NV_WAKE0: begin
              n.flag_attributes_reg[7:0] = NVM_DATA_I;
            end
            wcl_pkg::NV_WAKE1: begin
              n.flag_attributes_reg[15:8] = NVM_DATA_I & wcl_pkg::WK1_USED;
            end
            wcl_pkg::NV_LED0: begin
              n.led_en = NVM_DATA_I[3:0] & wcl_pkg::LED0_USED[3:0];
            end
            wcl_pkg::NV_LED1: begin
              if (!s.rst_prot) begin
                n.led_mode[7:0] = NVM_DATA_I;
              end
            end
            wcl_pkg::NV_LED2: begin
              if (!s.rst_prot) begin
                n.led_mode[15:8] = NVM_DATA_I;
              end
            end
            wcl_pkg::NV_LED3: begin
              if (!s.rst_prot) begin
                n.led_behav[7:0] = NVM_DATA_I;
              end
            end
            default: begin
              n.idx = s.idx;
            end
          endcase
          if (s.idx == wcl_pkg::NV_LED3) begin
            n.state = wcl_pkg::ST_FINISH;
          end else begin
            n.idx = s.idx + 3'h1;
          end
        end
      end
      wcl_pkg::ST_FINISH: begin
        // frame filter 0 takes its pattern from the store only when enabled
        n.wakeup_frame_filter_load = s.flag_attributes_reg[wcl_pkg::WK_MASTER] & s.flag_attributes_reg[wcl_pkg::WK_FRAME];
        ev[wcl_pkg::EV_DONE] = 1'b1;
        n.loaded = 1'b1;
        n.state = wcl_pkg::ST_IDLE;
      end
      wcl_pkg::ST_IDLE: begin
        n.state = wcl_pkg::ST_IDLE;
      end
      default: begin
        n.state = wcl_pkg::ST_BOOT;
      end
    endcase

    if (wr) begin
      case (PADDR_I)
        wcl_pkg::OFS_FLAG_ATTRIBUTES_REG: begin
          n.flag_attributes_reg = PWDATA_I[15:0] & {wcl_pkg::WK1_USED, 8'hff};
        end
        wcl_pkg::OFS_HARDWARE_CONFIG_REG: begin
          n.led_en = PWDATA_I[3:0];
          n.rst_prot = PWDATA_I[wcl_pkg::HW_PROT];
        end
        wcl_pkg::OFS_LED_MODE: begin
          n.led_mode = PWDATA_I[15:0];
        end
        wcl_pkg::OFS_LED_BEHAV: begin
          n.led_behav = PWDATA_I[15:0];
        end
        wcl_pkg::OFS_CTRL: begin
          if (PWDATA_I[wcl_pkg::CTRL_RELOAD]) begin
            n.state = wcl_pkg::ST_BOOT;
          end
        end
        wcl_pkg::OFS_INT_MASK: begin
          n.int_mask = PWDATA_I[2:0];
        end
        default: begin
          n.int_mask = n.int_mask;
        end
      endcase
    end

    // device-level reset: protected led registers keep their contents
    if (SOFT_RESET_I) begin
      n.flag_attributes_reg = wcl_pkg::FLAG_ATTRIBUTES_REG_RST;
      n.led_en = wcl_pkg::LED_EN_RST;
      if (!s.rst_prot) begin
        n.led_mode = wcl_pkg::LED_MODE_RST;
        n.led_behav = wcl_pkg::LED_BEHAV_RST;
      end
      n.loaded = 1'b0;
      n.state = wcl_pkg::ST_BOOT;
    end

    // attach pin: asserted level from polarity, release by driver type
    n.attach_act = att_en & USB_READY_I;
    if (att_en) begin
      n.attach = USB_READY_I ~^ s.flag_attributes_reg[wcl_pkg::WK_ATT_POL];
      n.attach_oe = s.flag_attributes_reg[wcl_pkg::WK_BUF] | ~n.attach;
    end else begin
      n.attach = 1'b0;
      n.attach_oe = 1'b0;
    end
    ev[wcl_pkg::EV_ATTACH] = n.attach_act & ~s.attach_act;

    if (s.flag_attributes_reg[wcl_pkg::WK_MASTER]) begin
      n.wake = {s.flag_attributes_reg[wcl_pkg::WK_FRAME], s.flag_attributes_reg[wcl_pkg::WK_BCAST],
                s.flag_attributes_reg[wcl_pkg::WK_PDA]};
    end else begin
      n.wake = 3'h0;
    end
    n.led = led_next;

    // a new event wins over a clearing write in the same cycle
    n.int_sts = s.int_sts;
    if (wr && PADDR_I == wcl_pkg::OFS_INT_STS) begin
      n.int_sts = s.int_sts & ~PWDATA_I[2:0];
    end
    n.int_sts = n.int_sts | ev;
    n.irq = |(n.int_sts & n.int_mask);

    // read data is captured in the setup cycle
    if (PSEL_I && !PENABLE_I) begin
      n.prdata = 32'h0;
      case (PADDR_I)
        wcl_pkg::OFS_FLAG_ATTRIBUTES_REG: begin
          n.prdata[15:0] = s.flag_attributes_reg;
        end
        wcl_pkg::OFS_HARDWARE_CONFIG_REG: begin
          n.prdata[3:0] = s.led_en;
          n.prdata[wcl_pkg::HW_PROT] = s.rst_prot;
          n.prdata[wcl_pkg::HW_LOADED] = s.loaded;
          n.prdata[wcl_pkg::HW_HSIC] = HSIC_MODE_I;
        end
        wcl_pkg::OFS_LED_MODE: begin
          n.prdata[15:0] = s.led_mode;
        end
        wcl_pkg::OFS_LED_BEHAV: begin
          n.prdata[15:0] = s.led_behav;
        end
        wcl_pkg::OFS_INT_STS: begin
          n.prdata[2:0] = s.int_sts;
        end
        wcl_pkg::OFS_INT_MASK: begin
          n.prdata[2:0] = s.int_mask;
        end
        default: begin
          n.prdata = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      s <= '0;
      s.state <= wcl_pkg::ST_BOOT;
      s.idx <= wcl_pkg::NV_WAKE0;
      s.flag_attributes_reg <= wcl_pkg::FLAG_ATTRIBUTES_REG_RST;
      s.led_en <= wcl_pkg::LED_EN_RST;
      s.led_mode <= wcl_pkg::LED_MODE_RST;
      s.led_behav <= wcl_pkg::LED_BEHAV_RST;
      s.int_sts <= wcl_pkg::INT_RST;
      s.int_mask <= wcl_pkg::INT_RST;
    end else begin
      s <= n;
    end
  end

  assign PRDATA_O = s.prdata;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~is_mapped(PADDR_I);
  assign NVM_REQ_O = (s.state == wcl_pkg::ST_FETCH);
  assign NVM_ADDR_O = s.idx;
  assign LED_O = s.led;
  assign ATTACH_O = s.attach;
  assign ATTACH_OE_O = s.attach_oe;
  assign WAKE_EN_O = s.wake;
  assign WAKE_FILTER0_LOAD_O = s.wakeup_frame_filter_load;
  assign IRQ_O = s.irq;

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RESET_N_I);

  property p_master_gate;
    !s.flag_attributes_reg[wcl_pkg::WK_MASTER] |=> WAKE_EN_O == 3'h0;
  endproperty
  a_master_gate: assert property (p_master_gate) else $error("wake enable without master");

  property p_pda_follow;
    s.flag_attributes_reg[wcl_pkg::WK_MASTER] |=> WAKE_EN_O[0] == $past(s.flag_attributes_reg[wcl_pkg::WK_PDA]);
  endproperty
  a_pda_follow: assert property (p_pda_follow) else $error("address wake mismatch");

  property p_pda_ignored;
    !s.flag_attributes_reg[wcl_pkg::WK_MASTER] && s.flag_attributes_reg[wcl_pkg::WK_PDA] |=> !WAKE_EN_O[0];
  endproperty
  a_pda_ignored: assert property (p_pda_ignored) else $error("address wake not gated");

  property p_wake1_load;
    s.state == wcl_pkg::ST_FETCH && NVM_ACK_I && s.idx == wcl_pkg::NV_WAKE1 && !wr &&
      !SOFT_RESET_I |=> s.flag_attributes_reg[15:8] == ($past(NVM_DATA_I) & wcl_pkg::WK1_USED);
  endproperty
  a_wake1_load: assert property (p_wake1_load) else $error("wake byte 1 not loaded");

  property p_open_drain;
    ATTACH_OE_O && ATTACH_O |-> $past(s.flag_attributes_reg[wcl_pkg::WK_BUF]);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drove high");

  property p_attach_level;
    att_en && USB_READY_I |=> ATTACH_O == $past(s.flag_attributes_reg[wcl_pkg::WK_ATT_POL]);
  endproperty
  a_attach_level: assert property (p_attach_level) else $error("attach level wrong");

  property p_attach_off;
    !att_en |=> !ATTACH_OE_O && !ATTACH_O;
  endproperty
  a_attach_off: assert property (p_attach_off) else $error("attach driven while off");

  property p_led_gate;
    !s.led_en[0] |=> !LED_O[0];
  endproperty
  a_led_gate: assert property (p_led_gate) else $error("disabled led lit");

  property p_protect;
    s.rst_prot && SOFT_RESET_I && !wr |=> $stable(s.led_mode) && $stable(s.led_behav);
  endproperty
  a_protect: assert property (p_protect) else $error("protected led register lost");

  sequence s_last_byte;
    s.state == wcl_pkg::ST_FETCH && NVM_ACK_I && s.idx == wcl_pkg::NV_LED3 && !SOFT_RESET_I &&
      !(wr && PADDR_I == wcl_pkg::OFS_CTRL);
  endsequence
  sequence s_finish;
    s.state == wcl_pkg::ST_FINISH ##1 s.loaded && s.int_sts[wcl_pkg::EV_DONE];
  endsequence
  property p_load_done;
    s_last_byte |=> s_finish;
  endproperty
  a_load_done: assert property (p_load_done) else $error("load did not complete");

endmodule

// File: wcl_nvm_model.sv
`timescale 1ns/100ps
module wcl_nvm_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic [2:0] addr_i,
  input wire logic [1:0] delay_i,
  input wire logic [47:0] image_i,
  output logic ack_o,
  output logic [7:0] data_o
);
  logic [1:0] wait_cnt;
  // one-cycle ack after delay_i idle cycles; data toggles while not valid
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_cnt <= 2'h0;
      ack_o <= 1'b0;
      data_o <= 8'h00;
    end else if (req_i && !ack_o && wait_cnt == delay_i) begin
      ack_o <= 1'b1;
      data_o <= image_i[addr_i * 8 +: 8];
      wait_cnt <= 2'h0;
    end else begin
      ack_o <= 1'b0;
      data_o <= ~data_o;
      wait_cnt <= (req_i && !ack_o) ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule

// File: testbench.sv
`timescale 1ns/100ps
module testbench;
  logic CLOCK_I = 1'b0;
  logic RESET_N_I = 1'b0;
  logic SOFT_RESET_I = 1'b0;
  logic PSEL_I = 1'b0;
  logic PENABLE_I = 1'b0;
  logic PWRITE_I = 1'b0;
  logic [4:0] PADDR_I = 5'h00;
  logic [31:0] PWDATA_I = 32'h0;
  logic NVM_PRESENT_I = 1'b1;
  logic HSIC_MODE_I = 1'b0;
  logic USB_READY_I = 1'b0;
  logic [15:0] LED_STATUS_I = 16'h0;
  logic [31:0] PRDATA_O;
  logic PREADY_O, PSLVERR_O, NVM_REQ_O, NVM_ACK_I, ATTACH_O, ATTACH_OE_O, IRQ_O;
  logic WAKE_FILTER0_LOAD_O;
  logic [2:0] NVM_ADDR_O, WAKE_EN_O;
  logic [7:0] NVM_DATA_I;
  logic [3:0] LED_O;
  logic [1:0] dly = 2'h0;
  logic [47:0] image = 48'h0;
  logic [31:0] seed = 32'h0000000c;
  logic [31:0] rd;
  logic err;
  int n_fail = 0;
  int samples_checked = 0;
  int n_pulse = 0;

  wcl_loader dut_u (.CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I), .SOFT_RESET_I(SOFT_RESET_I),
    .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
    .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .NVM_PRESENT_I(NVM_PRESENT_I), .NVM_REQ_O(NVM_REQ_O), .NVM_ADDR_O(NVM_ADDR_O),
    .NVM_ACK_I(NVM_ACK_I), .NVM_DATA_I(NVM_DATA_I), .HSIC_MODE_I(HSIC_MODE_I),
    .USB_READY_I(USB_READY_I), .LED_STATUS_I(LED_STATUS_I), .LED_O(LED_O),
    .ATTACH_O(ATTACH_O), .ATTACH_OE_O(ATTACH_OE_O), .WAKE_EN_O(WAKE_EN_O),
    .WAKE_FILTER0_LOAD_O(WAKE_FILTER0_LOAD_O), .IRQ_O(IRQ_O));
  wcl_nvm_model nvm_u (.clk_i(CLOCK_I), .rst_n_i(RESET_N_I), .req_i(NVM_REQ_O),
    .addr_i(NVM_ADDR_O), .delay_i(dly), .image_i(image), .ack_o(NVM_ACK_I),
    .data_o(NVM_DATA_I));

  initial begin
    forever #5 CLOCK_I = ~CLOCK_I;
  end
  always @(posedge CLOCK_I) begin
    if (WAKE_FILTER0_LOAD_O === 1'b1) n_pulse <= n_pulse + 1;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [3:0] exp_led(input logic [3:0] en, input logic [15:0] m,
                                         input logic [15:0] st);
    logic [3:0] r;
    for (int k = 0; k < 4; k++) begin
      r[k] = en[k] & st[m[k * 4 +: 4]];
    end
    return r;
  endfunction
  function automatic logic [1:0] exp_att(input logic [7:0] w1, input logic h, input logic u);
    logic lvl;
    lvl = (h & u) ? w1[4] : ~w1[4];
    return (w1[5] & h) ? {lvl, w1[6] | ~lvl} : 2'b00;
  endfunction

  task automatic end_sim();
    $display("compared %0d mismatched %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    int n;
    PSEL_I <= 1'b1;
    PWRITE_I <= wr;
    PADDR_I <= a;
    PWDATA_I <= wd;
    @(posedge CLOCK_I);
    PENABLE_I <= 1'b1;
    n = 0;
    do begin
      @(posedge CLOCK_I);
      n++;
    end while (PREADY_O !== 1'b1 && n < 20);
    rd = PRDATA_O;
    err = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
    // idle edge so the next call never re-raises psel in the same time step
    @(posedge CLOCK_I);
    if (n >= 20) begin
      n_fail++;
      end_sim();
    end
  endtask
  task automatic reload();
    int n;
    apb(1'b1, wcl_pkg::OFS_INT_STS, 32'h7);
    SOFT_RESET_I <= 1'b1;
    @(posedge CLOCK_I);
    SOFT_RESET_I <= 1'b0;
    for (n = 0; n < 200 && IRQ_O !== 1'b1; n++) @(posedge CLOCK_I);
    if (n >= 200) begin
      n_fail++;
      end_sim();
    end
    repeat (2) @(posedge CLOCK_I);
  endtask

  initial begin
    logic [7:0] w0, w1, l0, l1, l2, l3;
    logic [31:0] t;
    logic [15:0] exp_mode, exp_behav;
    logic prot;
    int n0;
    exp_mode = 16'h0;
    exp_behav = 16'h0;
    prot = 1'b0;
    repeat (12) @(posedge CLOCK_I);
    RESET_N_I <= 1'b1;
    @(posedge CLOCK_I);
    apb(1'b1, wcl_pkg::OFS_INT_MASK, 32'h1);
    for (int i = 0; i < 7; i++) begin
      t = rnd();
      {w0, w1, l0, l1} = rnd();
      {l2, l3} = t[31:16];
      if (i == 0) {w1, w0} = 16'hff7f;
      if (i == 1) {w1, w0} = 16'hffff;
      if (i == 4) apb(1'b1, wcl_pkg::OFS_HARDWARE_CONFIG_REG, 32'h10);
      if (i == 4) prot = 1'b1;
      image <= {l3, l2, l1, l0, w1, w0};
      dly <= t[1:0];
      HSIC_MODE_I <= (i == 1) | t[2];
      USB_READY_I <= t[3];
      LED_STATUS_I <= rnd();
      n0 = n_pulse;
      reload();
      if (!prot) exp_mode = {l2, l1};
      if (!prot) exp_behav = {8'h00, l3};
      apb(1'b0, wcl_pkg::OFS_FLAG_ATTRIBUTES_REG, 32'h0);
      chk(rd, {16'h0, w1 & 8'h73, w0}, "flags");
      apb(1'b0, wcl_pkg::OFS_HARDWARE_CONFIG_REG, 32'h0);
      chk(rd, {22'h0, HSIC_MODE_I, 1'b1, 3'h0, prot, l0[3:0]}, "hwcfg");
      apb(1'b0, wcl_pkg::OFS_LED_MODE, 32'h0);
      chk(rd, {16'h0, exp_mode}, "ledmode");
      apb(1'b0, wcl_pkg::OFS_LED_BEHAV, 32'h0);
      chk(rd, {16'h0, exp_behav}, "behav");
      chk(32'(WAKE_EN_O), w0[7] ? {w1[0], w1[1], w0[0]} : 32'h0, "wake");
      chk(n_pulse - n0, 32'(w0[7] & w1[0]), "filter0");
      chk(32'(LED_O), 32'(exp_led(l0[3:0], exp_mode, LED_STATUS_I)), "led");
      chk(32'({ATTACH_O, ATTACH_OE_O}), 32'(exp_att(w1, HSIC_MODE_I, USB_READY_I)), "att");
      apb(1'b0, wcl_pkg::OFS_INT_STS, 32'h0);
      chk(rd, {30'h0, w1[5] & HSIC_MODE_I & USB_READY_I, 1'b1}, "status");
    end
    apb(1'b1, wcl_pkg::OFS_INT_MASK, 32'h0);
    repeat (2) @(posedge CLOCK_I);
    chk(32'(IRQ_O), 32'h0, "masked");
    apb(1'b1, 5'h1c, 32'hffffffff);
    apb(1'b0, 5'h1c, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000, "unmapped");
    NVM_PRESENT_I <= 1'b0;
    apb(1'b1, wcl_pkg::OFS_INT_MASK, 32'h4);
    reload();
    apb(1'b0, wcl_pkg::OFS_FLAG_ATTRIBUTES_REG, 32'h0);
    chk(rd, 32'h0, "absent flags");
    apb(1'b1, wcl_pkg::OFS_INT_STS, 32'h7);
    repeat (2) @(posedge CLOCK_I);
    chk(32'(IRQ_O), 32'h0, "cleared");
    end_sim();
  end
endmodule
